// file: logic/dxtrg_core.sv
`timescale 1ns/1ps
`default_nettype none
module dxtrg_core
   import dxtrg_pkg::*;
(
   input  wire logic           ref_clk_i,
   input  wire logic           reset_n_i,
   input  wire logic           scan_select_i,
   input  wire logic           ext_break_i,
   input  wire dxtrg_reg_req_t reg_req_i,
   input  wire logic           core_go_i,
   input  wire dxtrg_events_t  events_i,
   input  wire dxtrg_bus_t     bus_i,
   output logic [31:0]         reg_rdata_o,
   output logic                reg_rvalid_o,
   output logic                core_halt_req_o,
   output logic                coproc_debug_irq_o,
   output logic                coproc_resume_o,
   output logic                data_trigger_o,
   output logic                pins_core_mode_o
);
   // pin inputs synchronised
   logic [1:0]    scan_sync_q;
   logic [1:0]    brk_sync_q;
   logic          rst_seen_q;
   logic          ide_q;
   logic [1:0]    cbrk_q;
   logic          go_hi_q;
   logic [3:0]    pbrk_q;
   logic [31:0]   value_q;
   logic [31:0]   mask_q;
   dxtrg_state_t  state_q;
   dxtrg_state_t  state_d;
   dxtrg_events_t ev;
   logic          cross_ev;
   logic          resume_now;
   logic          xcfg_wr;
   logic          match;
   logic [31:0]   xcfg_rd;
   logic [31:0]   lane_mask;
   logic [31:0]   bus_aligned;
   logic [3:0]    ev_hit;
   logic [31:0]   bit_hit;

   // strap sync runs through reset, settled at release
   always_ff @(posedge ref_clk_i) begin
      scan_sync_q <= {scan_sync_q[0], scan_select_i};
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         brk_sync_q <= 2'h0;
      end else begin
         brk_sync_q <= {brk_sync_q[0], ext_break_i};
      end
   end

   // strap captured first cycle after reset release
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         rst_seen_q <= 1'b0;
      end else begin
         rst_seen_q <= 1'b1;
      end
   end

   assign xcfg_wr = reg_req_i.wr && (reg_req_i.num == DXTRG_REG_XCFG);

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         ide_q <= 1'b0;
      end else if (!rst_seen_q) begin
         ide_q <= ~scan_sync_q[1];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         cbrk_q <= 2'h0;
      end else if (xcfg_wr) begin
         cbrk_q <= reg_req_i.wdata[DXTRG_CBRK_HI:DXTRG_CBRK_LO];
      end else if (!rst_seen_q) begin
         cbrk_q[0] <= ~scan_sync_q[1];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         go_hi_q <= DXTRG_GO_RST[1];
      end else if (xcfg_wr) begin
         go_hi_q <= reg_req_i.wdata[DXTRG_GO_HI];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         pbrk_q <= DXTRG_PBRK_RST;
      end else if (xcfg_wr) begin
         pbrk_q <= reg_req_i.wdata[DXTRG_PBRK_LO+3:DXTRG_PBRK_LO];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         value_q <= DXTRG_VALUE_RST;
      end else if (reg_req_i.wr && reg_req_i.num == DXTRG_REG_DATA_VALUE) begin
         value_q <= reg_req_i.wdata;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         mask_q <= DXTRG_MASK_RST;
      end else if (reg_req_i.wr && reg_req_i.num == DXTRG_REG_DATA_MASK) begin
         mask_q <= reg_req_i.wdata;
      end
   end

   always_comb begin
      lane_mask   = 32'hffff_ffff;
      bus_aligned = bus_i.data;
      case (bus_i.size)
         DXTRG_SIZE_BYTE: begin
            lane_mask   = 32'h0000_00ff;
            bus_aligned = {24'h0, bus_i.data[8*(3-bus_i.addr) +: 8]};
         end
         DXTRG_SIZE_WORD: begin
            lane_mask   = 32'h0000_ffff;
            bus_aligned = bus_i.addr[1] ? {16'h0, bus_i.data[15:0]}
                                        : {16'h0, bus_i.data[31:16]};
         end
         default: begin
            lane_mask   = 32'hffff_ffff;
            bus_aligned = bus_i.data;
         end
      endcase
   end

   // masked compare, one hit bit per data bit
   for (genvar b = 0; b < 32; b++) begin : g_bit
      assign bit_hit[b] = mask_q[b] || !lane_mask[b] ||
                          (bus_aligned[b] == value_q[b]);
   end

   assign match = bus_i.valid && (bit_hit == 32'hffff_ffff);

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         data_trigger_o <= 1'b0;
      end else begin
         data_trigger_o <= match;
      end
   end

   always_comb begin
      ev             = events_i;
      ev.ext_break   = brk_sync_q[1];
   end

   for (genvar k = 0; k < 4; k++) begin : g_event
      assign ev_hit[k] = ev[k] && pbrk_q[k];
   end

   assign cross_ev = ide_q && (ev_hit != 4'h0);

   assign resume_now = (go_hi_q && core_go_i) ||
                       (xcfg_wr && reg_req_i.wdata[DXTRG_GO_LO]);

   always_comb begin
      state_d = state_q;
      case (state_q)
         DXTRG_RUN: begin
            if (cross_ev) begin
               state_d = DXTRG_HALT;
            end
         end
         DXTRG_HALT: begin
            if (resume_now) begin
               state_d = DXTRG_RUN;
            end
         end
         default: state_d = DXTRG_RUN;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         state_q <= DXTRG_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         coproc_debug_irq_o <= 1'b0;
      end else begin
         coproc_debug_irq_o <= (state_d == DXTRG_HALT);
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         coproc_resume_o <= 1'b0;
      end else begin
         coproc_resume_o <= (state_q == DXTRG_HALT) && resume_now;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         core_halt_req_o <= 1'b0;
      end else begin
         core_halt_req_o <= ide_q &&
            ((cbrk_q[1] && cross_ev) || (cbrk_q[0] && brk_sync_q[1]));
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         pins_core_mode_o <= 1'b0;
      end else begin
         pins_core_mode_o <= ide_q;
      end
   end

   always_comb begin
      xcfg_rd = 32'h0;
      xcfg_rd[DXTRG_HALTED_BIT] = (state_q == DXTRG_HALT);
      xcfg_rd[DXTRG_IDE_BIT]    = ide_q;
      xcfg_rd[DXTRG_CBRK_HI:DXTRG_CBRK_LO] = cbrk_q;
      xcfg_rd[DXTRG_GO_HI]      = go_hi_q;
      xcfg_rd[DXTRG_PBRK_LO+3:DXTRG_PBRK_LO] = pbrk_q;
   end

   // mask has no read path
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         reg_rdata_o  <= 32'h0;
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= reg_req_i.rd;
         if (reg_req_i.rd && reg_req_i.num == DXTRG_REG_DATA_VALUE) begin
            reg_rdata_o <= value_q;
         end else if (reg_req_i.rd && reg_req_i.num == DXTRG_REG_XCFG) begin
            reg_rdata_o <= xcfg_rd;
         end else begin
            reg_rdata_o <= 32'h0;
         end
      end
   end
endmodule
`default_nettype wire

// file: pkg/dxtrg_pkg.sv
package dxtrg_pkg;
   // debug control register numbers
   localparam logic [4:0]  DXTRG_REG_DATA_VALUE = 5'h0e;
   localparam logic [4:0]  DXTRG_REG_DATA_MASK  = 5'h0f;
   localparam logic [4:0]  DXTRG_REG_XCFG       = 5'h10;
   // extended config/status field positions
   localparam int DXTRG_HALTED_BIT  = 28;
   localparam int DXTRG_IDE_BIT     = 27;
   localparam int DXTRG_CBRK_LO     = 22;
   localparam int DXTRG_CBRK_HI     = 23;
   localparam int DXTRG_GO_LO       = 20;
   localparam int DXTRG_GO_HI       = 21;
   localparam int DXTRG_PBRK_LO     = 16;
   // reset values and bus size codes
   localparam logic [31:0] DXTRG_VALUE_RST = 32'h0000_0000;
   localparam logic [31:0] DXTRG_MASK_RST  = 32'h0000_0000;
   localparam logic [3:0]  DXTRG_PBRK_RST  = 4'h0;
   localparam logic [1:0]  DXTRG_GO_RST    = 2'h0;
   localparam logic [1:0]  DXTRG_SIZE_BYTE = 2'h0;
   localparam logic [1:0]  DXTRG_SIZE_WORD = 2'h1;
   localparam logic [1:0]  DXTRG_SIZE_LONG = 2'h2;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [4:0]  num;
      logic [31:0] wdata;
   } dxtrg_reg_req_t;

   typedef struct packed {
      logic        valid;
      logic [1:0]  addr;
      logic [1:0]  size;
      logic [31:0] data;
   } dxtrg_bus_t;

   typedef struct packed {
      logic trig2;
      logic trig1;
      logic core_halted;
      logic ext_break;
   } dxtrg_events_t;

   typedef enum logic [1:0] {
      DXTRG_RUN  = 2'b01,
      DXTRG_HALT = 2'b10
   } dxtrg_state_t;
endpackage

// file: tb/dxtrg_core_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module dxtrg_core_monitor
   import dxtrg_pkg::*;
(
   input wire logic           ref_clk_i,
   input wire logic           reset_n_i,
   input wire dxtrg_reg_req_t reg_req_i,
   input wire logic [31:0]    reg_rdata_o,
   input wire logic           reg_rvalid_o,
   input wire logic           core_halt_req_o,
   input wire logic           coproc_debug_irq_o,
   input wire logic           coproc_resume_o,
   input wire logic           pins_core_mode_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!reset_n_i);
   sequence xcfg_rd;
      reg_req_i.rd && reg_req_i.num == DXTRG_REG_XCFG;
   endsequence
   sequence halt_drop;
      coproc_debug_irq_o ##1 !coproc_debug_irq_o;
   endsequence
   chk_rd_answer: assert property (
      reg_req_i.rd |=> reg_rvalid_o) else $error("no read answer");
   chk_mask_hidden: assert property (
      reg_req_i.rd && reg_req_i.num == DXTRG_REG_DATA_MASK
      |=> reg_rdata_o == 32'h0) else $error("mask readable");
   chk_go_reads_zero: assert property (
      xcfg_rd |=> !reg_rdata_o[DXTRG_GO_LO]) else $error("go bit read");
   chk_halt_status: assert property (
      xcfg_rd |=> reg_rdata_o[DXTRG_HALTED_BIT]
      == $past(coproc_debug_irq_o)) else $error("halt status wrong");
   chk_ide_status: assert property (
      xcfg_rd |=> reg_rdata_o[DXTRG_IDE_BIT] == pins_core_mode_o)
      else $error("enable status wrong");
   chk_off_quiet: assert property (
      !pins_core_mode_o |-> !coproc_debug_irq_o && !core_halt_req_o)
      else $error("cross debug active while off");
   chk_resume_pulse: assert property (
      coproc_resume_o |=> !coproc_resume_o) else $error("resume too long");
   chk_resume_halted: assert property (
      coproc_resume_o |-> $past(coproc_debug_irq_o) && !coproc_debug_irq_o)
      else $error("resume without halt");
   chk_halt_held: assert property (
      halt_drop |-> coproc_resume_o) else $error("halt dropped early");
endmodule
bind dxtrg_core dxtrg_core_monitor dxtrg_core_monitor_i (
   .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .reg_req_i(reg_req_i),
   .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
   .core_halt_req_o(core_halt_req_o), .coproc_resume_o(coproc_resume_o),
   .coproc_debug_irq_o(coproc_debug_irq_o),
   .pins_core_mode_o(pins_core_mode_o));
`default_nettype wire

// file: tb/dxtrg_core_test.sv
`timescale 1ns/1ps
`default_nettype none
module dxtrg_core_test
   import dxtrg_pkg::*;
;
   logic           ref_clk_i = 0, reset_n_i = 0, scan = 0, brk = 0;
   dxtrg_reg_req_t req;
   dxtrg_events_t  ev = '0;
   dxtrg_bus_t     bus = '0;
   logic [31:0]    rdata, d;
   logic           rvalid, go, halt, irq, res, trig, pins;
   int             n_mismatch = 0, cmp_count = 0, cyc = 0, i, j;
   always #12.5 ref_clk_i = ~ref_clk_i;
   dxtrg_core dxtrg_core_i (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
      .scan_select_i(scan), .ext_break_i(brk), .reg_req_i(req),
      .core_go_i(go), .events_i(ev), .bus_i(bus), .reg_rdata_o(rdata),
      .reg_rvalid_o(rvalid), .core_halt_req_o(halt),
      .coproc_debug_irq_o(irq), .coproc_resume_o(res),
      .data_trigger_o(trig), .pins_core_mode_o(pins));
   dxtrg_host_model host_i (.ref_clk_i(ref_clk_i), .rvalid_i(rvalid),
      .rdata_i(rdata), .reg_req_o(req), .core_go_o(go));
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic results;
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic cyc_n(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   task automatic bus_cmp(input logic [1:0] a, s, input logic [31:0] v,
                          input logic e);
      @(posedge ref_clk_i);
      #1 bus = '{1'b1, a, s, v};
      @(posedge ref_clk_i);
      #1 chk("trigger", trig, e);
      bus = '{1'b0, a, s, ~v};
   endtask
   // hang guard, run needs well under a thousand cycles
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         results;
      end
   end
   initial begin
      repeat (6) @(posedge ref_clk_i);
      #1 reset_n_i = 1;
      cyc_n(3);
      brk = 1;
      cyc_n(4);
      chk("core halt", halt, 1);
      brk = 0;
      host_i.rd(DXTRG_REG_XCFG, d);
      chk("xcfg", d & 32'h18ff_0000, 32'h0840_0000);
      host_i.rd(DXTRG_REG_DATA_MASK, d);
      chk("mask read", d, 0);
      host_i.rd(5'h03, d);
      chk("unmapped", d, 0);
      host_i.wr(DXTRG_REG_DATA_MASK, 32'h0000_0f00);
      host_i.wr(DXTRG_REG_DATA_VALUE, 32'h1234_56a5);
      host_i.rd(DXTRG_REG_DATA_VALUE, d);
      chk("value", d, 32'h1234_56a5);
      ev = 4'he;
      cyc_n(3);
      chk("no enable", irq, 0);
      ev = '0;
      $display("test registers done");
      for (i = 0; i < 4; i++) begin
         host_i.wr(DXTRG_REG_XCFG, 32'h1 << (DXTRG_PBRK_LO + i));
         if (i == 0) brk = 1;
         else ev = 4'h1 << i;
         cyc_n(4);
         brk = 0;
         ev = '0;
         cyc_n(3);
         chk("halt", irq, 1);
         host_i.go();
         cyc_n(2);
         chk("held", irq, 1);
         host_i.rd(DXTRG_REG_XCFG, d);
         chk("status", d[DXTRG_HALTED_BIT], 1);
         host_i.wr(DXTRG_REG_XCFG, (32'h1 << (16 + i)) | 32'h0010_0000);
         chk("resume", {res, irq}, 2'b10);
         host_i.rd(DXTRG_REG_XCFG, d);
         chk("go low", d[DXTRG_GO_HI:DXTRG_GO_LO], 0);
         chk("bit 22 written", d[DXTRG_CBRK_LO], 0);
         $display("test enable %0d done", i);
      end
      host_i.wr(DXTRG_REG_XCFG, 32'h00a8_0000);
      ev = 4'h8;
      cyc_n(2);
      chk("core halt", {halt, irq}, 2'b11);
      ev = '0;
      cyc_n(1);
      chk("core halt off", {halt, irq}, 2'b01);
      host_i.go();
      chk("go resume", {res, irq}, 2'b10);
      $display("test go done");
      for (i = 0; i < 4; i++)
         for (j = 0; j < 4; j++)
            bus_cmp(i[1:0], DXTRG_SIZE_BYTE, 32'ha5 << (8 * (3 - j)),
                    i == j);
      bus_cmp(2'h0, DXTRG_SIZE_WORD, 32'h50a5_0000, 1);
      bus_cmp(2'h2, DXTRG_SIZE_WORD, 32'h0000_56a5, 1);
      bus_cmp(2'h2, DXTRG_SIZE_WORD, 32'h56a5_0000, 0);
      bus_cmp(2'h1, DXTRG_SIZE_LONG, 32'h1234_50a5, 1);
      bus_cmp(2'h3, DXTRG_SIZE_LONG, 32'h1235_56a5, 0);
      $display("test data compare done");
      scan = 1;
      reset_n_i = 0;
      cyc_n(2);
      reset_n_i = 1;
      cyc_n(3);
      chk("pins", pins, 0);
      host_i.rd(DXTRG_REG_XCFG, d);
      chk("scan reset", d & 32'h0840_0000, 0);
      host_i.wr(DXTRG_REG_XCFG, 32'h0001_0000);
      brk = 1;
      cyc_n(4);
      chk("off", irq, 0);
      brk = 0;
      $display("test scan mode done");
      results;
   end
endmodule
`default_nettype wire

// file: tb/dxtrg_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module dxtrg_host_model
   import dxtrg_pkg::*;
(
   input  wire logic        ref_clk_i,
   input  wire logic        rvalid_i,
   input  wire logic [31:0] rdata_i,
   output dxtrg_reg_req_t   reg_req_o,
   output logic             core_go_o
);
   initial begin
      reg_req_o = '0;
      core_go_o = 1'b0;
   end
   // released data inverted so stale values never match
   task automatic wr(input logic [4:0] n, input logic [31:0] d);
      @(posedge ref_clk_i);
      #1 reg_req_o = {1'b1, 1'b0, n, d};
      @(posedge ref_clk_i);
      #1 reg_req_o = {1'b0, 1'b0, n, ~d};
   endtask
   task automatic rd(input logic [4:0] n, output logic [31:0] d);
      @(posedge ref_clk_i);
      #1 reg_req_o = {1'b0, 1'b1, n, 32'h0};
      @(posedge ref_clk_i);
      #1 reg_req_o = {1'b0, 1'b0, n, 32'hffff_ffff};
      d = rvalid_i ? rdata_i : 32'hxxxx_xxxx;
   endtask
   task automatic go;
      @(posedge ref_clk_i);
      #1 core_go_o = 1'b1;
      @(posedge ref_clk_i);
      #1 core_go_o = 1'b0;
   endtask
endmodule
`default_nettype wire
